// ===== rtl/aeia_pkg.sv
// Constants, register map and types of the address error and interrupt accept unit
// What this block does
// - Odd-address instruction fetch raises address error
// - Fetch from peripheral space raises address error
// - Single chip mode: external fetch is error
// - Odd-address word data access raises error
// - Unaligned longword data access raises error
// - Longword to 8-bit peripheral is error
// - Single chip mode: external data access errors
// - End bad cycle; process after instruction completes
// - Push status word, then next program counter
// - Fetch error vector, jump with no slot
// - Priority levels run zero to sixteen
// - Non-maskable input is level sixteen, unmaskable
// - Break and debug requests fixed level fifteen
// - Pins and peripherals programmable zero to fifteen
// - Resolver compares pending levels, picks winner
// - Maskable accepted only above mask field
// - On accept push, then load mask field
// - Non-maskable accept loads fifteen into mask
// - Fetch accepted source's vector, jump there
// - Sources: one NMI, break, four pins, peripherals
// - Each source has its own vector
// - Vector address is base plus four times number
package aeia_pkg;

  // Access sizes
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_LONG     = 2'h2;

  // Address spaces, inclusive bounds
  localparam logic [31:0] EXT_LO      = 32'h00400000;
  localparam logic [31:0] EXT_HI      = 32'hFFFEFFFF;
  localparam logic [31:0] PER_LO      = 32'hFFFF8000;
  localparam logic [31:0] PER_HI      = 32'hFFFFFFFF;
  localparam logic [31:0] PER8_LO     = 32'hFFFFF000;
  localparam logic [31:0] PER8_HI     = 32'hFFFFF7FF;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_SR      = 8'h04;
  localparam logic [7:0]  OFS_VBR     = 8'h08;
  localparam logic [7:0]  OFS_SP      = 8'h0C;
  localparam logic [7:0]  OFS_PRIO0   = 8'h10;
  localparam logic [7:0]  OFS_PRIO1   = 8'h14;
  localparam logic [7:0]  OFS_STAT    = 8'h18;
  localparam logic [7:0]  OFS_EADDR   = 8'h1C;

  // Fields and reset values
  localparam int          SR_MASK_LSB = 4;
  localparam logic [31:0] SR_RST      = 32'h000000F0;
  localparam logic [31:0] VBR_RST     = 32'h00000000;
  localparam logic [31:0] SP_RST      = 32'h00000000;
  localparam logic [31:0] PRIO_RST    = 32'h00000000;

  // Sources: 0 NMI, 1 break, 2 debug, 3..6 pins, 7..14 peripherals
  localparam int          N_IRQ       = 4;
  localparam int          N_PER       = 8;
  localparam int          N_SRC       = 3 + N_IRQ + N_PER;
  localparam logic [4:0]  LVL_NMI     = 5'h10;
  localparam logic [4:0]  LVL_FIX     = 5'h0F;
  localparam logic [3:0]  MASK_NMI    = 4'hF;

  // Vector numbers
  localparam logic [7:0]  VEC_AERR    = 8'h0A;
  localparam logic [7:0]  VEC_NMI     = 8'h0B;
  localparam logic [7:0]  VEC_UBC     = 8'h0C;
  localparam logic [7:0]  VEC_DBG     = 8'h0E;
  localparam logic [7:0]  VEC_IRQ0    = 8'h40;
  localparam logic [7:0]  VEC_PER0    = 8'h48;

  typedef enum logic [2:0] {
    S_IDLE, S_PUSH_SR, S_PUSH_PC, S_FETCH
  } aeia_state_t;

endpackage

// ===== rtl/aeia_unit.sv
// Address error checker, interrupt resolver and exception sequencer
`timescale 1ns/1ps
`default_nettype none
module aeia_unit
  import aeia_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        acc_valid,
  input  wire logic        acc_fetch,
  input  wire logic        acc_dma,
  input  wire logic [1:0]  acc_size,
  input  wire logic [31:0] acc_addr,
  output logic             acc_abort,
  input  wire logic        instr_done,
  input  wire logic [31:0] next_pc,
  input  wire logic        nmi_pin,
  input  wire logic        ubc_req,
  input  wire logic        dbg_req,
  input  wire logic [3:0]  irq_pin_n,
  input  wire logic [7:0]  periph_req,
  output logic             mem_req,
  output logic             mem_write,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  output logic             exc_busy,
  output logic             jump_valid,
  output logic      [31:0] jump_addr,
  output logic      [31:0] status_word
);

  aeia_state_t state_reg;
  logic [31:0] sr_reg;
  logic [31:0] vbr_reg;
  logic [31:0] sp_reg;
  logic [31:0] prio0_reg;
  logic [31:0] prio1_reg;
  logic        single_reg;
  logic        served_reg;
  logic [31:0] rdata_reg;
  logic        err_pend_reg;
  logic [31:0] eaddr_reg;
  logic        edma_reg;
  logic [31:0] ret_reg;
  logic [7:0]  vec_reg;
  logic        is_irq_reg;
  logic [4:0]  acc_lvl_reg;
  logic        nmi_s1_reg;
  logic        nmi_s2_reg;
  logic        nmi_s3_reg;
  logic        nmi_pend_reg;
  logic [3:0]  irq_s1_reg;
  logic [3:0]  irq_s2_reg;
  logic        req_reg;
  logic        wr_reg;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic        jv_reg;
  logic [31:0] jaddr_reg;

  logic [N_SRC-1:0] src_req;
  logic [4:0]  src_lvl [N_SRC];
  logic [4:0]  best_lvl;
  logic [3:0]  best_idx;
  logic        best_ok;
  logic        fault;
  logic        take;
  logic        bus_wr;
  logic [3:0]  mask;

  // Range test used by every space decode
  function automatic logic in_rng(input logic [31:0] a,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Vector number of each source, one per source
  function automatic logic [7:0] vec_of(input logic [3:0] idx);
    case (idx)
      4'h0:    vec_of = VEC_NMI;
      4'h1:    vec_of = VEC_UBC;
      4'h2:    vec_of = VEC_DBG;
      4'h3, 4'h4, 4'h5, 4'h6: vec_of = VEC_IRQ0 + {4'h0, idx - 4'h3};
      default: vec_of = VEC_PER0 + {4'h0, idx - 4'h7};
    endcase
  endfunction

  assign mask = sr_reg[SR_MASK_LSB +: 4];

  // Address error classification of the current bus cycle
  always_comb begin
    logic per;
    logic per8;
    logic ext;
    per  = in_rng(acc_addr, PER_LO, PER_HI);
    per8 = in_rng(acc_addr, PER8_LO, PER8_HI);
    ext  = in_rng(acc_addr, EXT_LO, EXT_HI);
    if (acc_fetch) begin
      fault = acc_addr[0]
            | per
            | (single_reg & ext);
    end else begin
      fault = ((acc_size == SZ_WORD) & acc_addr[0])
            | ((acc_size == SZ_LONG) & (acc_addr[1:0] != 2'h0))
            | ((acc_size == SZ_LONG) & per8)
            | (single_reg & ext);
    end
  end

  // Offending cycle is cut short at once
  assign acc_abort = acc_valid & fault;

  // Pin synchronisers and NMI edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      nmi_s3_reg <= 1'b0;
      irq_s1_reg <= 4'hF;
      irq_s2_reg <= 4'hF;
    end else begin
      nmi_s1_reg <= nmi_pin;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
      irq_s1_reg <= irq_pin_n;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // Sources and their levels, in fixed tie order
  always_comb begin
    src_req    = {periph_req, ~irq_s2_reg, dbg_req, ubc_req, nmi_pend_reg};
    src_lvl[0] = LVL_NMI;
    src_lvl[1] = LVL_FIX;
    src_lvl[2] = LVL_FIX;
    for (int i = 0; i < N_IRQ; i++) begin
      src_lvl[3+i] = {1'b0, prio0_reg[4*i +: 4]};
    end
    for (int i = 0; i < N_PER; i++) begin
      src_lvl[7+i] = {1'b0, prio1_reg[4*i +: 4]};
    end
  end

  // Resolver: highest eligible level, lower index wins ties
  always_comb begin
    best_ok  = 1'b0;
    best_lvl = 5'h00;
    best_idx = 4'h0;
    for (int i = 0; i < N_SRC; i++) begin
      if (src_req[i] && ((i == 0) || (src_lvl[i] > {1'b0, mask}))
          && (!best_ok || (src_lvl[i] > best_lvl))) begin
        best_ok  = 1'b1;
        best_lvl = src_lvl[i];
        best_idx = 4'(i);
      end
    end
  end

  // Address errors take precedence over interrupts at a boundary
  assign take = (state_reg == S_IDLE) & instr_done
              & (err_pend_reg | acc_abort | best_ok);

  // Pending address error; one taken at once is not kept pending
  always_ff @(posedge clk) begin
    if (reset) begin
      err_pend_reg <= 1'b0;
      eaddr_reg    <= 32'h00000000;
      edma_reg     <= 1'b0;
    end else begin
      if (take && (err_pend_reg || acc_abort)) begin
        err_pend_reg <= 1'b0;
      end
      if (acc_abort) begin
        err_pend_reg <= ~take;
        eaddr_reg    <= acc_addr;
        edma_reg     <= acc_dma;
      end
    end
  end

  // NMI pending flag, a fresh edge wins over acceptance
  always_ff @(posedge clk) begin
    if (reset) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_s2_reg && !nmi_s3_reg) begin
      nmi_pend_reg <= 1'b1;
    end else if (take && !err_pend_reg && !acc_abort && best_idx == 4'h0) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // Exception sequencer with its memory port
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg   <= S_IDLE;
      ret_reg     <= 32'h00000000;
      vec_reg     <= 8'h00;
      is_irq_reg  <= 1'b0;
      acc_lvl_reg <= 5'h00;
      req_reg     <= 1'b0;
      wr_reg      <= 1'b0;
      addr_reg    <= 32'h00000000;
      wdata_reg   <= 32'h00000000;
      jv_reg      <= 1'b0;
      jaddr_reg   <= 32'h00000000;
    end else begin
      jv_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            ret_reg    <= next_pc;
            is_irq_reg <= ~(err_pend_reg | acc_abort);
            vec_reg    <= (err_pend_reg | acc_abort) ? VEC_AERR
                                                     : vec_of(best_idx);
            acc_lvl_reg <= best_lvl;
            req_reg    <= 1'b1;
            wr_reg     <= 1'b1;
            addr_reg   <= sp_reg - 32'h4;
            wdata_reg  <= sr_reg;
            state_reg  <= S_PUSH_SR;
          end
        end
        S_PUSH_SR: begin
          if (mem_ack) begin
            addr_reg  <= sp_reg - 32'h8; // Pointer drops at this same edge
            wdata_reg <= ret_reg;
            state_reg <= S_PUSH_PC;
          end
        end
        S_PUSH_PC: begin
          if (mem_ack) begin
            wr_reg    <= 1'b0;
            addr_reg  <= vbr_reg + {22'h0, vec_reg, 2'h0};
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            req_reg   <= 1'b0;
            jv_reg    <= 1'b1;
            jaddr_reg <= mem_rdata;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          req_reg   <= 1'b0;
        end
      endcase
    end
  end

  assign mem_req     = req_reg;
  assign mem_write   = wr_reg;
  assign mem_addr    = addr_reg;
  assign mem_wdata   = wdata_reg;
  assign jump_valid  = jv_reg;
  assign jump_addr   = jaddr_reg;
  assign exc_busy    = (state_reg != S_IDLE);
  assign status_word = sr_reg;

  // Avalon slave: one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~served_reg;
  assign bus_wr          = avs_write & served_reg;
  assign avs_readdata    = rdata_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      served_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else begin
      served_reg <= (avs_read | avs_write) & ~served_reg;
      if (avs_read && !served_reg) begin
        case (avs_address)
          OFS_CTRL:  rdata_reg <= {31'h0, single_reg};
          OFS_SR:    rdata_reg <= sr_reg;
          OFS_VBR:   rdata_reg <= vbr_reg;
          OFS_SP:    rdata_reg <= sp_reg;
          OFS_PRIO0: rdata_reg <= prio0_reg;
          OFS_PRIO1: rdata_reg <= prio1_reg;
          OFS_STAT:  rdata_reg <= {16'h0, vec_reg, acc_lvl_reg,
                                   edma_reg, err_pend_reg, exc_busy};
          OFS_EADDR: rdata_reg <= eaddr_reg;
          default:   rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      single_reg <= 1'b0;
      vbr_reg    <= VBR_RST;
      prio0_reg  <= PRIO_RST;
      prio1_reg  <= PRIO_RST;
    end else if (bus_wr) begin
      if (avs_address == OFS_CTRL && avs_byteenable[0]) begin
        single_reg <= avs_writedata[0];
      end
      if (avs_address == OFS_VBR) begin
        vbr_reg <= merge(vbr_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == OFS_PRIO0) begin
        prio0_reg <= merge(prio0_reg, avs_writedata,
                           avs_byteenable) & 32'h0000FFFF;
      end
      if (avs_address == OFS_PRIO1) begin
        prio1_reg <= merge(prio1_reg, avs_writedata, avs_byteenable);
      end
    end
  end

  // Status word: sequencer's mask load beats a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      sr_reg <= SR_RST;
    end else if (state_reg == S_PUSH_SR && mem_ack && is_irq_reg) begin
      sr_reg[SR_MASK_LSB +: 4] <= (acc_lvl_reg == LVL_NMI) ? MASK_NMI
                                  : acc_lvl_reg[3:0];
    end else if (bus_wr && avs_address == OFS_SR) begin
      sr_reg <= merge(sr_reg, avs_writedata, avs_byteenable);
    end
  end

  // Stack pointer drops one word per push
  always_ff @(posedge clk) begin
    if (reset) begin
      sp_reg <= SP_RST;
    end else if ((state_reg == S_PUSH_SR || state_reg == S_PUSH_PC)
                 && mem_ack) begin
      sp_reg <= sp_reg - 32'h4;
    end else if (bus_wr && avs_address == OFS_SP) begin
      sp_reg <= merge(sp_reg, avs_writedata, avs_byteenable);
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fetch_odd_err: assert property (
    acc_valid && acc_fetch && acc_addr[0] |-> acc_abort)
    else $error("odd fetch not aborted");
  a_fetch_per_err: assert property (
    acc_valid && acc_fetch && acc_addr >= PER_LO |-> acc_abort)
    else $error("peripheral fetch not aborted");
  a_ext_single_err: assert property (
    acc_valid && single_reg && acc_addr >= EXT_LO && acc_addr <= EXT_HI
    |-> acc_abort)
    else $error("external access in single chip mode allowed");
  a_word_odd_err: assert property (
    acc_valid && !acc_fetch && acc_size == SZ_WORD && acc_addr[0]
    |-> acc_abort)
    else $error("odd word access not aborted");
  a_long_align_err: assert property (
    acc_valid && !acc_fetch && acc_size == SZ_LONG && acc_addr[1:0] != 2'h0
    |-> acc_abort)
    else $error("unaligned longword not aborted");
  a_per8_long_err: assert property (
    acc_valid && !acc_fetch && acc_size == SZ_LONG
    && acc_addr >= PER8_LO && acc_addr <= PER8_HI |-> acc_abort)
    else $error("longword to 8-bit peripheral allowed");
  a_wait_boundary: assert property (
    state_reg == S_IDLE && !instr_done |=> state_reg == S_IDLE)
    else $error("exception started before instruction end");
  a_push_order: assert property (
    state_reg == S_PUSH_SR && mem_ack
    |=> state_reg == S_PUSH_PC && mem_wdata == $past(ret_reg)
        && mem_addr == $past(mem_addr) - 32'h4)
    else $error("program counter not pushed after status word");
  a_vector_addr: assert property (
    state_reg == S_PUSH_PC && mem_ack
    |=> mem_addr == vbr_reg + {22'h0, vec_reg, 2'h0} && !mem_write)
    else $error("vector address wrong");
  a_jump_pulse: assert property (
    state_reg == S_FETCH && mem_ack
    |=> jump_valid && jump_addr == $past(mem_rdata) ##1 !jump_valid)
    else $error("jump not issued for one cycle");
  a_nmi_mask: assert property (
    state_reg == S_PUSH_SR && mem_ack && is_irq_reg && acc_lvl_reg == LVL_NMI
    |=> status_word[SR_MASK_LSB +: 4] == MASK_NMI)
    else $error("mask not fifteen after NMI");
  a_accept_above: assert property (
    take && !err_pend_reg && !acc_abort && best_idx != 4'h0
    |-> best_lvl > {1'b0, mask})
    else $error("interrupt accepted at or below mask");

  c_addr_error: cover property (take && err_pend_reg ##[1:20] jump_valid);
  c_nmi_accept: cover property (take && best_ok && best_idx == 4'h0);
  c_irq_accept: cover property (take && best_ok && best_idx > 4'h2);
  c_bus_read:   cover property (avs_read && !avs_waitrequest);

endmodule // aeia_unit
`default_nettype wire

// ===== tb/aeia_mem_model.sv
// Stack and vector table memory that answers the exception sequencer
`timescale 1ns/1ps
`default_nettype none
module aeia_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  output logic      [31:0] mem_rdata,
  output logic             mem_ack
);
  logic [1:0]  wait_reg;
  logic [31:0] noise_reg;

  // Acknowledge after no wait or after three wait cycles
  assign mem_ack = mem_req && (wait_reg == (slow ? 2'h3 : 2'h0));
  // Vector entries are a scramble of their address; idle data flips
  assign mem_rdata = (mem_ack && !mem_write) ? (mem_addr ^ 32'h5A5AA5A5)
                                             : noise_reg;

  // Wait counter runs while a request is outstanding
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg  <= 2'h0;
      noise_reg <= 32'h0;
    end else begin
      noise_reg <= ~noise_reg;
      if (!mem_req || mem_ack) begin
        wait_reg <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule // aeia_mem_model
`default_nettype wire

// ===== tb/aeia_unit_tb_top.sv
// Self-checking bench for the address error and interrupt accept unit
`timescale 1ns/1ps
`default_nettype none
module aeia_unit_tb_top;
  import aeia_pkg::*;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, single;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        acc_valid, acc_fetch, acc_dma, acc_abort, instr_done;
  logic [1:0]  acc_size;
  logic [31:0] acc_addr, next_pc;
  logic        nmi_pin, ubc_req, dbg_req, slow;
  logic [3:0]  irq_pin_n;
  logic [7:0]  periph_req;
  logic        mem_req, mem_write, mem_ack, exc_busy, jump_valid;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, jump_addr, status_word;
  logic [31:0] sp, sr, vector_base, seed, rd;
  logic [64:0] exp_mem[$];
  logic [31:0] exp_jmp[$];
  int          error_cnt, compares;

  // Access table: single chip, fetch, size, abort expected, address
  localparam logic [36:0] ROWS [15] = '{
    {2'b01, SZ_BYTE, 1'b0, 32'h00400000},
    {2'b01, SZ_BYTE, 1'b1, 32'h00000101},
    {2'b01, SZ_BYTE, 1'b1, 32'hFFFF8000},
    {2'b00, SZ_WORD, 1'b1, 32'h00000003},
    {2'b00, SZ_WORD, 1'b0, 32'h00000002},
    {2'b00, SZ_LONG, 1'b1, 32'h00000006},
    {2'b00, SZ_LONG, 1'b0, 32'h00000004},
    {2'b00, SZ_LONG, 1'b1, 32'hFFFFF000},
    {2'b00, SZ_LONG, 1'b0, 32'hFFFF8000},
    {2'b00, SZ_WORD, 1'b0, 32'hFFFFF7FE},
    {2'b00, SZ_BYTE, 1'b0, 32'hFFFFF001},
    {2'b11, SZ_BYTE, 1'b1, 32'h00400000},
    {2'b11, SZ_BYTE, 1'b0, 32'h00000100},
    {2'b10, SZ_BYTE, 1'b1, 32'hFFFEFFFF},
    {2'b10, SZ_WORD, 1'b0, 32'h003FFFFE}
  };

  aeia_unit dut (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_valid(acc_valid), .acc_fetch(acc_fetch), .acc_dma(acc_dma),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_abort(acc_abort),
    .instr_done(instr_done), .next_pc(next_pc), .nmi_pin(nmi_pin),
    .ubc_req(ubc_req), .dbg_req(dbg_req), .irq_pin_n(irq_pin_n),
    .periph_req(periph_req), .mem_req(mem_req), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .exc_busy(exc_busy), .jump_valid(jump_valid),
    .jump_addr(jump_addr), .status_word(status_word)
  );

  aeia_mem_model mem (
    .clk(clk), .reset(reset), .slow(slow), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pseudo-random step
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // Verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare a value or flag
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Compare a stack or vector memory transfer
  task automatic cmp_mem(input logic [64:0] g, input logic [64:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One register access; held until an edge samples waitrequest low
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h0);
    cmp_val(rd, e);
  endtask

  task automatic set_sr(input logic [3:0] m);
    wr(OFS_SR, {24'h0, m, 4'h0});
    sr = {24'h0, m, 4'h0};
  endtask

  // Instruction boundary that must start an exception
  task automatic run_exc(input logic [7:0] vec, input logic intr,
                         input logic [3:0] m);
    logic [31:0] pc, va;
    int          n;
    pc = {seed[31:1], 1'b0};
    va = vector_base + {22'h0, vec, 2'h0};
    n  = 0;
    exp_mem.push_back({1'b1, sp - 32'h4, sr});
    exp_mem.push_back({1'b1, sp - 32'h8, pc});
    exp_mem.push_back({1'b0, va, 32'h0});
    exp_jmp.push_back(va ^ 32'h5A5AA5A5);
    sp = sp - 32'h8;
    if (intr) sr[7:4] = m;
    @(posedge clk);
    slow       <= seed[3];
    instr_done <= 1'b1;
    next_pc    <= pc;
    seed = xs(seed);
    @(posedge clk);
    instr_done <= 1'b0;
    @(negedge clk);
    while (exc_busy !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) error_cnt++;
    @(negedge clk);
    cmp_val(status_word, sr);
  endtask

  // Instruction boundary that must not start anything
  task automatic no_exc();
    @(posedge clk);
    instr_done <= 1'b1;
    next_pc    <= 32'h00000100;
    @(posedge clk);
    instr_done <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_val({30'h0, exc_busy, mem_req}, 32'h0);
  endtask

  // Monitor: memory transfers and jumps against the oldest notes
  always @(negedge clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      cmp_mem({mem_write, mem_addr, mem_write ? mem_wdata : 32'h0},
              exp_mem.size() > 0 ? exp_mem.pop_front() : {65{1'bx}});
    end
    if (jump_valid === 1'b1) begin
      cmp_val(jump_addr,
              exp_jmp.size() > 0 ? exp_jmp.pop_front() : {32{1'bx}});
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {reset, avs_read, avs_write, acc_valid, acc_fetch, acc_dma} = 6'h21;
    {instr_done, nmi_pin, ubc_req, dbg_req, slow, single} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    acc_size = SZ_BYTE;
    acc_addr = 32'h0;
    next_pc = 32'h0;
    irq_pin_n = 4'hF;
    periph_req = 8'h00;
    seed = 32'hCF53;
    sp = 32'h00002000;
    vector_base = 32'h00001000;
    sr = SR_RST;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdchk(OFS_SR, SR_RST);
    rdchk(OFS_VBR, VBR_RST);
    rdchk(OFS_PRIO0, PRIO_RST);
    wr(8'h20, 32'hFFFFFFFF);
    rdchk(8'h20, 32'h0);
    wr(OFS_VBR, vector_base);
    wr(OFS_SP, sp);
    rdchk(OFS_SP, sp);
    // Walk the access table
    for (int i = 0; i < 15; i++) begin
      if (ROWS[i][36] !== single) begin
        single = ROWS[i][36];
        wr(OFS_CTRL, {31'h0, single});
      end
      @(posedge clk);
      acc_valid <= 1'b1;
      acc_fetch <= ROWS[i][35];
      acc_size  <= ROWS[i][34:33];
      acc_addr  <= ROWS[i][31:0];
      acc_dma   <= seed[0];
      seed = xs(seed);
      @(negedge clk);
      cmp_val({31'h0, acc_abort}, {31'h0, ROWS[i][32]});
      @(posedge clk);
      acc_valid <= 1'b0;
    end
    wr(OFS_CTRL, 32'h0);
    rdchk(OFS_EADDR, 32'hFFFEFFFF);
    cmp_val({31'h0, exc_busy}, 32'h0);
    run_exc(VEC_AERR, 1'b0, 4'h0);
    // Interrupt acceptance and priority
    set_sr(4'h0);
    wr(OFS_PRIO0, 32'h00002553);
    wr(OFS_PRIO1, 32'h00000004);
    rdchk(OFS_PRIO0, 32'h00002553);
    @(posedge clk);
    irq_pin_n  <= 4'b1001;
    periph_req <= 8'h01;
    repeat (4) @(posedge clk);
    run_exc(VEC_IRQ0 + 8'h01, 1'b1, 4'h5);
    no_exc();
    wr(OFS_PRIO1, 32'h00000006);
    run_exc(VEC_PER0, 1'b1, 4'h6);
    @(posedge clk);
    irq_pin_n  <= 4'hF;
    periph_req <= 8'h00;
    ubc_req    <= 1'b1;
    set_sr(4'hE);
    run_exc(VEC_UBC, 1'b1, 4'hF);
    @(posedge clk);
    ubc_req <= 1'b0;
    dbg_req <= 1'b1;
    no_exc();
    set_sr(4'h3);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge clk);
    run_exc(VEC_NMI, 1'b1, 4'hF);
    @(posedge clk);
    nmi_pin <= 1'b0;
    dbg_req <= 1'b0;
    repeat (4) @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge clk);
    run_exc(VEC_NMI, 1'b1, 4'hF);
    // Level zero never passes a zero mask
    set_sr(4'h0);
    wr(OFS_PRIO0, 32'h00002550);
    irq_pin_n <= 4'b1110;
    repeat (4) @(posedge clk);
    no_exc();
    cmp_val(exp_mem.size() + exp_jmp.size(), 32'h0);
    wrap_up();
  end
endmodule // aeia_unit_tb_top
`default_nettype wire
